// ### lih_top.sv
// What this block does
// R1: enabled active link drives interrupt low
// R2: master summary: one bit per link
// R3: master summary unlatched; access leaves interrupt alone
// R4: link bits 5..1 latch receive events
// R5: link bit 0 summarises thirteen overflows
// R6: bit 0 drops when mask or status clears
// R7: zero clears bits 5..1; ones change nothing
// R8: reading link status clears nothing
// R9: link mask enables each of six sources
// R10: link0 bit 7 summarises group overflow
// R11: link0 bit 6 latches transfer/frame end
// R12: handler enables eight sources, reports them
// R13: link0 bits 7,6 masked by one
// R14: pcm overflow flags gated by counter enable
// R15: input overflow flags latch, zero write clears
// R16: group summary shows enabled group overflow
// R17: group mask passes group overflow upward
// R18: group flags latch five overflow sources
// R19: group fifo overflow has own enable
// R20: enabled counter wrap raises overflow
// R21: command code enables or masks counter
// R22: no read side effects on status
// R23: interrupt high when nothing enabled active
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module lih_top (
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_avs_address,
   input  wire logic        i_avs_read,
   input  wire logic        i_avs_write,
   input  wire logic [31:0] i_avs_writedata,
   input  wire logic [3:0]  i_avs_byteenable,
   output logic      [31:0] o_avs_readdata,
   output logic             o_avs_waitrequest,
   input  wire logic [39:0] i_link_evt,
   input  wire logic [95:0] i_link_cnt_wrap,
   input  wire logic [7:0]  i_link_fifo_ovf,
   input  wire logic [7:0]  i_link_uni,
   input  wire logic [15:0] i_grp_cnt_wrap,
   input  wire logic [3:0]  i_grp_fifo_ovf,
   input  wire logic [3:0]  i_icp_done,
   input  wire logic [3:0]  i_frame_end,
   output logic             o_irq_n
);
   localparam int NL  = lih_pkg::NUM_LINKS;
   localparam int NG  = lih_pkg::NUM_GROUPS;
   localparam int CPL = lih_pkg::CNT_PER_LINK;
   localparam int PC  = lih_pkg::PCM_CNT;
   localparam int UC  = lih_pkg::UTX_CNT;
   localparam int NE  = lih_pkg::LINK_EVTS;
   localparam int SW  = lih_pkg::SEL_W;
   localparam logic [SW-1:0] NCNT = SW'(lih_pkg::NUM_CNT);

   // port widths and the counter map are fixed by these counts
   if ($bits(i_link_evt) != NL*NE ||
       $bits(i_link_cnt_wrap) != NL*CPL ||
       $bits(i_grp_cnt_wrap) != NG*UC ||
       lih_pkg::GRP_CNT_BASE != NL*CPL ||
       lih_pkg::NUM_CNT != NL*CPL + NG*UC ||
       lih_pkg::NUM_CNT > 2**SW) begin : g_bad_counts
      $error("package counts do not match the ports");
   end

   // set wins over a clearing zero written in the same cycle
   function automatic logic [7:0] upd(input logic [7:0] q,
                                      input logic [7:0] set,
                                      input logic [7:0] clrable,
                                      input logic       hit,
                                      input logic [7:0] wd);
      logic [7:0] clr;
      clr = hit ? (clrable & ~wd) : 8'h00;
      return (q & ~clr) | set;
   endfunction

   function automatic logic blk(input logic [7:0] a,
                                input logic [7:0] base);
      return a[7:3] == base[7:3];
   endfunction

   lih_pkg::lih_bus_type st_q, st_d;
   logic                wait_q, wait_d;
   logic [31:0]         rdata_q, rdata_d;
   logic                irq_n_q, irq_n_d;
   logic [7:0]          master_mask_q, master_mask_d;
   logic [3:0]          grp_mask_q, grp_mask_d;
   logic [3:0]          grp_fifo_en_q, grp_fifo_en_d;
   logic [7:0]          lnk_fifo_en_q, lnk_fifo_en_d;
   logic [7:0]          hdl_q, hdl_d;
   logic [7:0]          hdl_en_q, hdl_en_d;
   logic [6:0]          cnt_sel_q, cnt_sel_d;
   logic [111:0]        cnt_en_q, cnt_en_d;
   logic [7:0]          link_lat_q [NL];
   logic [7:0]          link_lat_d [NL];
   logic [7:0]          link_mask_q [NL];
   logic [7:0]          link_mask_d [NL];
   logic [7:0]          pcm_q [NL];
   logic [7:0]          pcm_d [NL];
   logic [4:0]          inovf_q [NL];
   logic [4:0]          inovf_d [NL];
   logic [4:0]          grp_q [NG];
   logic [4:0]          grp_d [NG];

   logic [7:0]          pcm_gt [NL];
   logic [4:0]          in_gt [NL];
   logic [4:0]          grp_gt [NG];
   logic [7:0]          link_stat [NL];
   logic [7:0]          link_en [NL];
   logic [NL-1:0]       link_sum;
   logic [NG-1:0]       grp_sum;
   logic [7:0]          a8;
   logic [7:0]          wd;
   logic                wr_ev;
   logic                hdl_set;
   logic [7:0]          rd;

   assign a8    = i_avs_address;
   assign wd    = i_avs_writedata[7:0];
   // a write lands on the edge where the master sees waitrequest low
   assign wr_ev = (st_q == lih_pkg::BUS_ACK) & i_avs_write &
                  i_avs_byteenable[0];

   // status tree, all unlatched summaries
   always_comb begin
      for (int g = 0; g < NG; g++) begin
         grp_gt[g]  = {grp_fifo_en_q[g],                           // R19
                       cnt_en_q[lih_pkg::GRP_CNT_BASE + g*UC +: UC]};
         grp_sum[g] = grp_mask_q[g] & (|(grp_q[g] & grp_gt[g]));   // R16 R17
      end
      for (int l = 0; l < NL; l++) begin
         pcm_gt[l] = cnt_en_q[l*CPL +: PC];                        // R14
         in_gt[l]  = {lnk_fifo_en_q[l] & i_link_uni[l],
                      cnt_en_q[l*CPL + PC +: UC]};
         link_stat[l] = link_lat_q[l] & lih_pkg::LINK0_LAT_BITS;
         // masking or clearing the last active source drops bit 0 at once
         link_stat[l][0] = (|(pcm_q[l] & pcm_gt[l])) |
                           (|(inovf_q[l] & in_gt[l]));             // R5 R6
         link_en[l] = link_mask_q[l] & lih_pkg::LINK_OWN_BITS;     // R9
      end
      link_stat[0][7] = |grp_sum;                                   // R10
      // the two group-level sources use an inverted (mask) sense
      link_en[0] = link_en[0] |
                   (~link_mask_q[0] & lih_pkg::LINK0_INV_BITS);     // R13
      for (int l = 0; l < NL; l++) begin
         link_sum[l] = |(link_stat[l] & link_en[l]);                // R2
      end
   end

   // register and latch updates
   always_comb begin
      master_mask_d = master_mask_q;
      grp_mask_d    = grp_mask_q;
      grp_fifo_en_d = grp_fifo_en_q;
      lnk_fifo_en_d = lnk_fifo_en_q;
      hdl_en_d      = hdl_en_q;
      cnt_sel_d     = cnt_sel_q;
      cnt_en_d      = cnt_en_q;
      hdl_set = |({i_frame_end, i_icp_done} & hdl_en_q);           // R12
      hdl_d = upd(hdl_q, {i_frame_end, i_icp_done}, lih_pkg::ALL_BITS,
                  wr_ev && a8 == lih_pkg::ADR_HDL_FLAGS, wd);       // R12
      if (wr_ev) begin
         unique case (a8)
            lih_pkg::ADR_MASTER_MASK: master_mask_d = wd;
            lih_pkg::ADR_GRP_MASK:    grp_mask_d    = wd[3:0];       // R17
            lih_pkg::ADR_GRP_FIFO_EN: grp_fifo_en_d = wd[3:0];       // R19
            lih_pkg::ADR_LNK_FIFO_EN: lnk_fifo_en_d = wd;
            lih_pkg::ADR_HDL_EN:      hdl_en_d      = wd;
            lih_pkg::ADR_CNT_SEL:     cnt_sel_d     = wd[6:0];
            lih_pkg::ADR_CNT_CMD: begin
               if (cnt_sel_q < NCNT) begin
                  if (!wd[lih_pkg::CMD_EN_ZERO] &&
                      wd[5:0] == lih_pkg::CMD_EN_CODE) begin
                     cnt_en_d[cnt_sel_q] = 1'b1;                     // R21
                  end else if (wd[4:0] == lih_pkg::CMD_DIS_CODE) begin
                     cnt_en_d[cnt_sel_q] = 1'b0;                     // R21
                  end
               end
            end
            default: ;
         endcase
      end
      for (int l = 0; l < NL; l++) begin
         link_mask_d[l] = (wr_ev && a8 == lih_pkg::ADR_LINK_MASK + 8'(l))
                          ? wd : link_mask_q[l];
         link_lat_d[l] = upd(link_lat_q[l],
                             {1'b0, (l == 0) && hdl_set,            // R11
                              i_link_evt[l*NE +: NE], 1'b0},        // R4
                             (l == 0) ? lih_pkg::LINK0_LAT_BITS
                                      : lih_pkg::LAT_BITS,
                             wr_ev && a8 == lih_pkg::ADR_LINK_FLAGS + 8'(l),
                             wd);                                   // R7
         pcm_d[l] = upd(pcm_q[l],
                        i_link_cnt_wrap[l*CPL +: PC] & pcm_gt[l],   // R20
                        lih_pkg::ALL_BITS,
                        wr_ev && a8 == lih_pkg::ADR_PCM_FLAGS + 8'(l), wd);
         inovf_d[l] = 5'(upd({3'b000, inovf_q[l]},
                        {3'b000, i_link_fifo_ovf[l] & i_link_uni[l],
                         i_link_cnt_wrap[l*CPL + PC +: UC] &
                         cnt_en_q[l*CPL + PC +: UC]},
                        lih_pkg::LOW5_BITS,
                        wr_ev && a8 == lih_pkg::ADR_INOVF_FLAGS + 8'(l),
                        wd));                                       // R15
      end
      for (int g = 0; g < NG; g++) begin
         grp_d[g] = 5'(upd({3'b000, grp_q[g]},
                      {3'b000, i_grp_fifo_ovf[g],
                       i_grp_cnt_wrap[g*UC +: UC] &
                       cnt_en_q[lih_pkg::GRP_CNT_BASE + g*UC +: UC]},
                      lih_pkg::LOW5_BITS,
                      wr_ev && a8 == lih_pkg::ADR_GRP_FLAGS + 8'(g),
                      wd));                                         // R18
      end
      irq_n_d = ~|(link_sum & master_mask_q);                       // R1 R23
   end

   // bus answer; reads only select data, never touch state
   always_comb begin
      rd = lih_pkg::RST_REG;
      unique case (a8)
         lih_pkg::ADR_MASTER_SUM:  rd = link_sum;                    // R3
         lih_pkg::ADR_MASTER_MASK: rd = master_mask_q;
         lih_pkg::ADR_GRP_SUM:     rd = {4'h0, grp_sum};
         lih_pkg::ADR_GRP_MASK:    rd = {4'h0, grp_mask_q};
         lih_pkg::ADR_GRP_FIFO_EN: rd = {4'h0, grp_fifo_en_q};
         lih_pkg::ADR_LNK_FIFO_EN: rd = lnk_fifo_en_q;
         lih_pkg::ADR_HDL_FLAGS:   rd = hdl_q;
         lih_pkg::ADR_HDL_EN:      rd = hdl_en_q;
         lih_pkg::ADR_CNT_SEL:     rd = {1'b0, cnt_sel_q};
         lih_pkg::ADR_CNT_CMD:
            rd = {7'h00, (cnt_sel_q < NCNT) && cnt_en_q[cnt_sel_q]};
         default: begin
            if (blk(a8, lih_pkg::ADR_LINK_FLAGS)) begin
               rd = link_stat[a8[2:0]];                             // R8 R22
            end else if (blk(a8, lih_pkg::ADR_LINK_MASK)) begin
               rd = link_mask_q[a8[2:0]];
            end else if (blk(a8, lih_pkg::ADR_PCM_FLAGS)) begin
               rd = pcm_q[a8[2:0]];
            end else if (blk(a8, lih_pkg::ADR_INOVF_FLAGS)) begin
               rd = {3'b000, inovf_q[a8[2:0]]};
            end else if (blk(a8, lih_pkg::ADR_GRP_FLAGS) && !a8[2]) begin
               rd = {3'b000, grp_q[a8[1:0]]};
            end
         end
      endcase
   end

   always_comb begin
      st_d    = st_q;
      wait_d  = wait_q;
      rdata_d = rdata_q;
      unique case (st_q)
         lih_pkg::BUS_IDLE: begin
            if (i_avs_read || i_avs_write) begin
               st_d    = lih_pkg::BUS_ACK;
               wait_d  = 1'b0;
               rdata_d = {24'h000000, rd};
            end
         end
         lih_pkg::BUS_ACK: begin
            st_d   = lih_pkg::BUS_IDLE;
            wait_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q          <= lih_pkg::BUS_IDLE;
         wait_q        <= 1'b1;
         rdata_q       <= 32'h00000000;
         irq_n_q       <= 1'b1;
         master_mask_q <= lih_pkg::RST_REG;
         grp_mask_q    <= 4'h0;
         grp_fifo_en_q <= 4'h0;
         lnk_fifo_en_q <= lih_pkg::RST_REG;
         hdl_q         <= lih_pkg::RST_REG;
         hdl_en_q      <= lih_pkg::RST_REG;
         cnt_sel_q     <= 7'h00;
         cnt_en_q      <= '0;
         for (int l = 0; l < NL; l++) begin
            link_lat_q[l]  <= lih_pkg::RST_REG;
            link_mask_q[l] <= lih_pkg::RST_REG;
            pcm_q[l]       <= lih_pkg::RST_REG;
            inovf_q[l]     <= 5'h00;
         end
         for (int g = 0; g < NG; g++) begin
            grp_q[g] <= 5'h00;
         end
      end else begin
         st_q          <= st_d;
         wait_q        <= wait_d;
         rdata_q       <= rdata_d;
         irq_n_q       <= irq_n_d;
         master_mask_q <= master_mask_d;
         grp_mask_q    <= grp_mask_d;
         grp_fifo_en_q <= grp_fifo_en_d;
         lnk_fifo_en_q <= lnk_fifo_en_d;
         hdl_q         <= hdl_d;
         hdl_en_q      <= hdl_en_d;
         cnt_sel_q     <= cnt_sel_d;
         cnt_en_q      <= cnt_en_d;
         link_lat_q    <= link_lat_d;
         link_mask_q   <= link_mask_d;
         pcm_q         <= pcm_d;
         inovf_q       <= inovf_d;
         grp_q         <= grp_d;
      end
   end

   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_irq_n           = irq_n_q;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence

   // any selected counter, any enable code with the don't-care bit
   sequence s_en_cmd;
      wr_ev && a8 == lih_pkg::ADR_CNT_CMD && cnt_sel_q < NCNT &&
      !wd[lih_pkg::CMD_EN_ZERO] && wd[5:0] == lih_pkg::CMD_EN_CODE;
   endsequence

   sequence s_hdl_evt;
      i_icp_done[0] && hdl_en_q[0];
   endsequence

   AST_IRQ_LOW: assert property ( // R1
      (link_sum & master_mask_q) != 8'h00 |=> !o_irq_n)
      else $error("irq not asserted");

   AST_IRQ_HIGH: assert property ( // R23
      (link_sum & master_mask_q) == 8'h00 |=> o_irq_n)
      else $error("irq asserted idle");

   AST_BUS_ACK: assert property (
      (i_avs_read || i_avs_write) && st_q == lih_pkg::BUS_IDLE |=> s_ack)
      else $error("bad handshake");

   AST_MASTER_RD: assert property ( // R2
      st_q == lih_pkg::BUS_IDLE && i_avs_read &&
      a8 == lih_pkg::ADR_MASTER_SUM |=>
      o_avs_readdata[7:0] == $past(link_sum)) else $error("summary");

   AST_READ_KEEP: assert property ( // R8
      !wr_ev |=> ($past(link_lat_q[0]) & ~link_lat_q[0]) == 8'h00)
      else $error("latch lost");

   AST_ZERO_CLR: assert property ( // R7
      wr_ev && a8 == lih_pkg::ADR_LINK_FLAGS && !wd[1] && !i_link_evt[0]
      |=> !link_lat_q[0][1]) else $error("zero write");

   AST_SET_WINS: assert property ( // R4
      i_link_evt[0] |=> link_lat_q[0][1]) else $error("event lost");

   AST_CMD_EN: assert property ( // R21
      s_en_cmd |=> cnt_en_q[$past(cnt_sel_q)])
      else $error("counter enable");

   AST_LINK0_MASK: assert property ( // R13
      link_lat_q[0][6] && !link_mask_q[0][6] |-> link_sum[0])
      else $error("link0 bit6");

   AST_HDL_LINK0: assert property ( // R11 R12
      s_hdl_evt |=> link_lat_q[0][6])
      else $error("handler event lost");

   // counter 27 is link 2, pcm counter 3
   AST_PCM_SET: assert property ( // R20
      i_link_cnt_wrap[27] && cnt_en_q[27] |=> pcm_q[2][3])
      else $error("pcm wrap lost");

   AST_INOVF_SET: assert property ( // R15
      i_link_fifo_ovf[1] && i_link_uni[1] |=> inovf_q[1][4])
      else $error("fifo overflow lost");

   AST_GRP_SET: assert property ( // R18
      i_grp_fifo_ovf[2] |=> grp_q[2][4])
      else $error("group overflow lost");

   AST_RD_NO_CLR: assert property ( // R22
      i_avs_read && !i_avs_write |=>
      ($past(pcm_q[2]) & ~pcm_q[2]) == 8'h00 &&
      ($past(inovf_q[1]) & ~inovf_q[1]) == 5'h00 &&
      ($past(grp_q[2]) & ~grp_q[2]) == 5'h00)
      else $error("read cleared status");
endmodule
`default_nettype wire

// ### lih_pkg.sv
`default_nettype none
package lih_pkg;
   localparam int NUM_LINKS    = 8;
   localparam int NUM_GROUPS   = 4;
   localparam int LINK_EVTS    = 5;
   localparam int CNT_PER_LINK = 12;
   localparam int PCM_CNT      = 8;
   localparam int UTX_CNT      = 4;
   localparam int NUM_CNT      = 112;
   localparam int GRP_CNT_BASE = 96;
   localparam int SEL_W        = 7;
   localparam int ADDR_W       = 8;

   // word offsets on the register bus
   localparam logic [7:0] ADR_MASTER_SUM  = 8'h00;
   localparam logic [7:0] ADR_MASTER_MASK = 8'h01;
   localparam logic [7:0] ADR_GRP_SUM     = 8'h02;
   localparam logic [7:0] ADR_GRP_MASK    = 8'h03;
   localparam logic [7:0] ADR_GRP_FIFO_EN = 8'h04;
   localparam logic [7:0] ADR_LNK_FIFO_EN = 8'h05;
   localparam logic [7:0] ADR_HDL_FLAGS   = 8'h06;
   localparam logic [7:0] ADR_HDL_EN      = 8'h07;
   localparam logic [7:0] ADR_CNT_SEL     = 8'h08;
   localparam logic [7:0] ADR_CNT_CMD     = 8'h09;
   localparam logic [7:0] ADR_GRP_FLAGS   = 8'h10;
   localparam logic [7:0] ADR_LINK_FLAGS  = 8'h20;
   localparam logic [7:0] ADR_LINK_MASK   = 8'h28;
   localparam logic [7:0] ADR_PCM_FLAGS   = 8'h30;
   localparam logic [7:0] ADR_INOVF_FLAGS = 8'h38;

   localparam logic [7:0] RST_REG        = 8'h00;
   localparam logic [7:0] LAT_BITS       = 8'h3E;
   localparam logic [7:0] LINK0_LAT_BITS = 8'h7E;
   localparam logic [7:0] LINK_OWN_BITS  = 8'h3F;
   localparam logic [7:0] LINK0_INV_BITS = 8'hC0;
   localparam logic [7:0] ALL_BITS       = 8'hFF;
   localparam logic [7:0] LOW5_BITS      = 8'h1F;

   localparam logic [5:0] CMD_EN_CODE  = 6'h0A;
   localparam logic [4:0] CMD_DIS_CODE = 5'h02;
   localparam int         CMD_EN_ZERO  = 7;

   typedef enum logic {BUS_IDLE, BUS_ACK} lih_bus_type;
endpackage
`default_nettype wire

// ### lih_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module lih_top_tb_top;
   typedef struct {int lnk; int bt; logic [7:0] exp;} lih_row_type;
   logic        i_clk, i_rst, i_avs_read, i_avs_write;
   logic [7:0]  i_avs_address, i_link_fifo_ovf, i_link_uni, rd;
   logic [31:0] i_avs_writedata, o_avs_readdata;
   logic [3:0]  i_avs_byteenable, i_grp_fifo_ovf, i_icp_done, i_frame_end;
   logic        o_avs_waitrequest, o_irq_n;
   logic [39:0] i_link_evt;
   logic [95:0] i_link_cnt_wrap;
   logic [15:0] i_grp_cnt_wrap;
   int          failures, cmp_count;
   lih_row_type rows [6] = '{'{0, 1, 8'h02}, '{3, 2, 8'h04}, '{5, 3, 8'h08},
                            '{6, 4, 8'h10}, '{7, 5, 8'h20}, '{1, 5, 8'h20}};

   lih_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
      .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
      .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
      .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
      .i_link_evt(i_link_evt), .i_link_cnt_wrap(i_link_cnt_wrap),
      .i_link_fifo_ovf(i_link_fifo_ovf), .i_link_uni(i_link_uni),
      .i_grp_cnt_wrap(i_grp_cnt_wrap), .i_grp_fifo_ovf(i_grp_fifo_ovf),
      .i_icp_done(i_icp_done), .i_frame_end(i_frame_end), .o_irq_n(o_irq_n));

   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // request held up to the rising edge that samples waitrequest low;
   // one idle edge after release so strobes never change twice at once
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      i_avs_address <= a;
      i_avs_read <= ~w;
      i_avs_write <= w;
      i_avs_writedata <= {24'h0, d};
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 40);
      if (n >= 40) begin
         failures++;
         give_verdict();
      end
      rd = o_avs_readdata[7:0];
      i_avs_read <= 1'b0;
      i_avs_write <= 1'b0;
      @(posedge i_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(rd, exp);
   endtask

   task automatic irq(input logic exp);
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      chk({7'h0, o_irq_n}, {7'h0, exp});
      @(posedge i_clk);
   endtask

   task automatic give_verdict;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      #500us;
      failures++;
      give_verdict();
   end

   initial begin
      i_rst = 1'b1;
      {i_avs_read, i_avs_write, i_avs_address, i_avs_writedata} = '0;
      i_avs_byteenable = 4'hF;
      {i_link_evt, i_link_cnt_wrap, i_link_fifo_ovf, i_grp_cnt_wrap} = '0;
      {i_grp_fifo_ovf, i_icp_done, i_frame_end} = '0;
      i_link_uni = 8'h02;
      repeat (6) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      irq(1'b1);
      rdc(lih_pkg::ADR_MASTER_MASK, 8'h00);
      rdc(lih_pkg::ADR_LINK_MASK, 8'h00);
      foreach (rows[r]) begin
         i_link_evt[rows[r].lnk * 5 + rows[r].bt - 1] <= 1'b1;
         @(posedge i_clk);
         i_link_evt <= '0;
         @(posedge i_clk);
         rdc(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), rows[r].exp);
         rdc(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), rows[r].exp);
         rdc(lih_pkg::ADR_MASTER_SUM, 8'h00);
         irq(1'b1);
         wr(lih_pkg::ADR_LINK_MASK + 8'(rows[r].lnk), rows[r].exp);
         wr(lih_pkg::ADR_MASTER_MASK, 8'h01 << rows[r].lnk);
         irq(1'b0);
         rdc(lih_pkg::ADR_MASTER_SUM, 8'h01 << rows[r].lnk);
         irq(1'b0);
         wr(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), 8'hFF);
         rdc(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), rows[r].exp);
         wr(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), 8'h00);
         rdc(lih_pkg::ADR_LINK_FLAGS + 8'(rows[r].lnk), 8'h00);
         irq(1'b1);
         wr(lih_pkg::ADR_LINK_MASK + 8'(rows[r].lnk), 8'h00);
      end
      // counter 27 is link 2, pcm counter 3
      wr(lih_pkg::ADR_CNT_SEL, 8'h1B);
      i_link_cnt_wrap[27] <= 1'b1;
      @(posedge i_clk);
      i_link_cnt_wrap <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_PCM_FLAGS + 8'h02, 8'h00);
      wr(lih_pkg::ADR_CNT_CMD, {2'b00, lih_pkg::CMD_EN_CODE});
      i_link_cnt_wrap[27] <= 1'b1;
      @(posedge i_clk);
      i_link_cnt_wrap <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_PCM_FLAGS + 8'h02, 8'h08);
      wr(lih_pkg::ADR_LINK_MASK + 8'h02, 8'h01);
      wr(lih_pkg::ADR_MASTER_MASK, 8'h04);
      irq(1'b0);
      wr(lih_pkg::ADR_LINK_FLAGS + 8'h02, 8'h00);
      rdc(lih_pkg::ADR_LINK_FLAGS + 8'h02, 8'h01);
      wr(lih_pkg::ADR_CNT_CMD, {3'b000, lih_pkg::CMD_DIS_CODE});
      rdc(lih_pkg::ADR_LINK_FLAGS + 8'h02, 8'h00);
      irq(1'b1);
      wr(lih_pkg::ADR_CNT_CMD, {2'b00, lih_pkg::CMD_EN_CODE});
      irq(1'b0);
      wr(lih_pkg::ADR_PCM_FLAGS + 8'h02, 8'h00);
      irq(1'b1);
      wr(lih_pkg::ADR_LINK_MASK + 8'h02, 8'h00);
      // receive fifo overflow on link 1 in UNI mode
      i_link_fifo_ovf <= 8'h02;
      @(posedge i_clk);
      i_link_fifo_ovf <= '0;
      @(posedge i_clk);
      wr(lih_pkg::ADR_LNK_FIFO_EN, 8'h02);
      wr(lih_pkg::ADR_LINK_MASK + 8'h01, 8'h01);
      wr(lih_pkg::ADR_MASTER_MASK, 8'h02);
      irq(1'b0);
      wr(lih_pkg::ADR_LNK_FIFO_EN, 8'h00);
      irq(1'b1);
      wr(lih_pkg::ADR_LNK_FIFO_EN, 8'h02);
      irq(1'b0);
      wr(lih_pkg::ADR_INOVF_FLAGS + 8'h01, 8'h00);
      irq(1'b1);
      wr(lih_pkg::ADR_LINK_MASK + 8'h01, 8'h00);
      // link 3 is not in UNI mode: its fifo overflow is not latched
      i_link_fifo_ovf <= 8'h08;
      @(posedge i_clk);
      i_link_fifo_ovf <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_INOVF_FLAGS + 8'h03, 8'h00);
      // group 2 receive fifo overflow up to link 0 bit 7
      i_grp_fifo_ovf <= 4'h4;
      @(posedge i_clk);
      i_grp_fifo_ovf <= '0;
      @(posedge i_clk);
      wr(lih_pkg::ADR_GRP_FIFO_EN, 8'h04);
      rdc(lih_pkg::ADR_GRP_SUM, 8'h00);
      wr(lih_pkg::ADR_GRP_MASK, 8'h04);
      rdc(lih_pkg::ADR_GRP_SUM, 8'h04);
      rdc(lih_pkg::ADR_LINK_FLAGS, 8'h80);
      wr(lih_pkg::ADR_MASTER_MASK, 8'h01);
      irq(1'b0);
      wr(lih_pkg::ADR_MASTER_SUM, 8'hFF);
      irq(1'b0);
      wr(lih_pkg::ADR_LINK_MASK, 8'h80);
      irq(1'b1);
      wr(lih_pkg::ADR_LINK_MASK, 8'h00);
      irq(1'b0);
      wr(lih_pkg::ADR_GRP_FIFO_EN, 8'h00);
      irq(1'b1);
      rdc(lih_pkg::ADR_GRP_SUM, 8'h00);
      wr(lih_pkg::ADR_GRP_FLAGS + 8'h02, 8'h00);
      wr(lih_pkg::ADR_GRP_FIFO_EN, 8'h04);
      rdc(lih_pkg::ADR_GRP_SUM, 8'h00);
      // group 1 transmit counter 2 is counter 102
      wr(lih_pkg::ADR_CNT_SEL, 8'h66);
      wr(lih_pkg::ADR_CNT_CMD, {2'b00, lih_pkg::CMD_EN_CODE});
      rdc(lih_pkg::ADR_CNT_CMD, 8'h01);
      i_grp_cnt_wrap <= 16'h0040;
      @(posedge i_clk);
      i_grp_cnt_wrap <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_GRP_FLAGS + 8'h01, 8'h04);
      // handler sources: group 0 ready and group 1 frame end
      wr(lih_pkg::ADR_HDL_EN, 8'h21);
      i_icp_done <= 4'h1;
      i_frame_end <= 4'h2;
      @(posedge i_clk);
      i_icp_done <= '0;
      i_frame_end <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_HDL_FLAGS, 8'h21);
      rdc(lih_pkg::ADR_LINK_FLAGS, 8'h40);
      irq(1'b0);
      wr(lih_pkg::ADR_LINK_MASK, 8'h40);
      irq(1'b1);
      wr(lih_pkg::ADR_LINK_MASK, 8'h00);
      wr(lih_pkg::ADR_LINK_FLAGS, 8'h00);
      rdc(lih_pkg::ADR_LINK_FLAGS, 8'h00);
      wr(lih_pkg::ADR_HDL_FLAGS, 8'h00);
      rdc(lih_pkg::ADR_HDL_FLAGS, 8'h00);
      i_frame_end <= 4'h8;
      @(posedge i_clk);
      i_frame_end <= '0;
      @(posedge i_clk);
      rdc(lih_pkg::ADR_LINK_FLAGS, 8'h00);
      irq(1'b1);
      // refused accesses
      rdc(8'h50, 8'h00);
      i_avs_byteenable <= 4'h0;
      wr(lih_pkg::ADR_MASTER_MASK, 8'hFF);
      i_avs_byteenable <= 4'hF;
      rdc(lih_pkg::ADR_MASTER_MASK, 8'h01);
      // mid-run reset drops a pending interrupt and every latch
      i_icp_done <= 4'h1;
      @(posedge i_clk);
      i_icp_done <= '0;
      irq(1'b0);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_rst <= 1'b0;
      @(posedge i_clk);
      irq(1'b1);
      rdc(lih_pkg::ADR_LINK_FLAGS, 8'h00);
      rdc(lih_pkg::ADR_MASTER_MASK, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
